// ==== src/adsq_regs.svh ====
/*
  Register offsets, field positions, reset values and timing counts of the
  ADC conversion sequencer. Assumes a 12-bit APB byte address and 32-bit data.
*/
`ifndef ADSQ_REGS_SVH
`define ADSQ_REGS_SVH

// ------------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------------
`define ADSQ_OFF_CTRL     12'h000
`define ADSQ_OFF_CFG      12'h004
`define ADSQ_OFF_STAT_A   12'h008
`define ADSQ_OFF_STAT_B   12'h00C
`define ADSQ_OFF_TEST_A   12'h010
`define ADSQ_OFF_TEST_B   12'h014
`define ADSQ_OFF_RES0     12'h020
`define ADSQ_OFF_RES7     12'h03C

// ------------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------------
`define ADSQ_CTL_MULTICHANNEL_SELECT     4
`define ADSQ_CTL_SCAN     5
`define ADSQ_CTL_EIGHT    6
`define ADSQ_CFG_FFC      0
`define ADSQ_CFG_PWR      1
`define ADSQ_STB_SCF      7
`define ADSQ_TSTB_RST     7
`define ADSQ_TSTB_TOUT    6

// ------------------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------------------
`define ADSQ_CTL_RESET    7'h00
`define ADSQ_SAR_INIT     10'h200
`define ADSQ_SAMPLE_CYC   4

`endif

// ==== src/adsq_pkg.sv ====
/*
  Types shared by the ADC conversion sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package adsq_pkg;

  // Sequencer states
  typedef enum logic [1:0] {
    st_idle,
    st_sample,
    st_resolve,
    st_store
  } adsq_state_t;

  // Analog multiplexer select code
  typedef logic [3:0] adsq_sel_t;

endpackage

// ==== src/adsq_top.sv ====
/*
  Conversion sequencer of an 8-bit successive-approximation ADC: channel
  selection, result storage, completion flags, pointer, test registers.
  Assumes an APB master on pclk, an analog mux driven by analog_sel and a
  comparator answering cmp_high (input above dac_code) within one cycle.
*/
// Notes on behaviour
// - Multichannel set converts consecutive channels; clear converts one selected channel.
// - Single-channel mode samples only the input named by the select bits.
// - Multichannel mode ignores don't-care select bits, ascending order from input 0 or 8 (eight-mode) or 0, 4, 8 or 12 (four-mode).
// - Top bit 0 analog inputs; 11 references and test; 10 reserved.
// - Four-mode stores to results 0-3, eight-mode to 0-7, in sequence order.
// - Without scanning, sequence done flag sets when the sequence ends.
// - With scanning, done flag sets at first sequence end; converting continues.
// - Writing the mode control register clears done flag and starts a sequence.
// - With fast clearing, first result read clears the sequence done flag.
// - A 3-bit pointer shows channel converting and result written next.
// - One channel done flag per result slot, set when its conversion completes.
// - Without fast clearing, flag clears after status A read then result read.
// - With fast clearing, any result read clears its channel done flag.
// - Status registers always readable; writable only in special mode.
// - Test registers read zero and ignore writes outside special mode.
// - Approximation field reads live value, write loads it; upper eight bits used.
// - Soft reset returns everything to reset state except power-up enable.
// - Four-bit test select picks a test mode; one bit routes test output.
// - Results hold left-justified unsigned values, always readable, normal writes ignored.
// - Eight-conversion bit selects eight conversions when set, four when clear.
// - Continuous bit selects repeated sequences when set, one per start when clear.
// - Control write mid-sequence aborts it and clears all done flags.
`timescale 1ns/1ps
`include "adsq_regs.svh"

module adsq_top #(
  parameter int ADDR_W     = 12,
  parameter int SAMPLE_CYC = `ADSQ_SAMPLE_CYC
) (
  // Clock, reset, enable
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Chip mode
  input  wire logic              special_mode,
  // Analog side
  input  wire logic              cmp_high,
  output adsq_pkg::adsq_sel_t    analog_sel,
  output logic                   analog_sel_valid,
  output logic [7:0]             dac_code,
  // Factory test
  output logic [3:0]             factory_test_select,
  output logic                   factory_test_output
);
  import adsq_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [6:0]  mode_channel_control;
  logic        fast_flag_clear;
  logic        power_up_enable;
  logic        sequence_done_flag;
  logic        seq_ended;
  logic [7:0]  channel_done_flags;
  logic [7:0]  status_armed;
  logic [2:0]  conversion_pointer;
  logic [9:0]  approximation_register_bits;
  logic [3:0]  bit_idx;
  logic [3:0]  sample_cnt;
  logic [7:0]  result_bits [8];
  adsq_state_t state;

  logic        sel_ctl, sel_cfg, sel_sta, sel_stb, sel_ta, sel_tb, sel_res;
  logic [2:0]  res_idx;
  logic [31:0] rdata;
  logic        xfer, wr, rd, start, soft_rst, store_evt, last;
  logic        multichannel_select, eight_conversion_mode, scan;
  adsq_sel_t   next_sel;

  assign multichannel_select   = mode_channel_control[`ADSQ_CTL_MULTICHANNEL_SELECT];
  assign scan                  = mode_channel_control[`ADSQ_CTL_SCAN];
  assign eight_conversion_mode = mode_channel_control[`ADSQ_CTL_EIGHT];
  assign dac_code              = approximation_register_bits[9:2];

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  // Address decode; exact word offsets, anything else is an error
  always_comb begin
    sel_ctl = 1'b0;
    sel_cfg = 1'b0;
    sel_sta = 1'b0;
    sel_stb = 1'b0;
    sel_ta  = 1'b0;
    sel_tb  = 1'b0;
    sel_res = 1'b0;
    res_idx = paddr[4:2];
    if (paddr == `ADSQ_OFF_CTRL) begin
      sel_ctl = 1'b1;
    end else if (paddr == `ADSQ_OFF_CFG) begin
      sel_cfg = 1'b1;
    end else if (paddr == `ADSQ_OFF_STAT_A) begin
      sel_sta = 1'b1;
    end else if (paddr == `ADSQ_OFF_STAT_B) begin
      sel_stb = 1'b1;
    end else if (paddr == `ADSQ_OFF_TEST_A) begin
      sel_ta = 1'b1;
    end else if (paddr == `ADSQ_OFF_TEST_B) begin
      sel_tb = 1'b1;
    end else if (paddr >= `ADSQ_OFF_RES0 && paddr <= `ADSQ_OFF_RES7
                 && paddr[1:0] == 2'b00) begin
      sel_res = 1'b1;
    end
  end

  // Transfer completes at the edge where pready is seen high
  assign xfer     = psel & penable & pready;
  assign wr       = xfer & pwrite;
  assign rd       = xfer & ~pwrite;
  assign start    = wr & sel_ctl & pstrb[0];
  assign soft_rst = wr & sel_tb & pstrb[0] & special_mode
                    & pwdata[`ADSQ_TSTB_RST];

  // Read mux; test registers hide outside special mode
  always_comb begin
    rdata = 32'h0000_0000;
    if (sel_ctl) begin
      rdata = {25'h0, mode_channel_control};
    end else if (sel_cfg) begin
      rdata = {30'h0, power_up_enable, fast_flag_clear};
    end else if (sel_sta) begin
      rdata = {24'h0, channel_done_flags};
    end else if (sel_stb) begin
      rdata = {24'h0, sequence_done_flag, 4'h0, conversion_pointer};
    end else if (sel_ta && special_mode) begin
      rdata = {22'h0, approximation_register_bits};
    end else if (sel_tb && special_mode) begin
      rdata = {24'h0, 1'b0, factory_test_output, 2'h0, factory_test_select};
    end else if (sel_res) begin
      rdata = {24'h0, result_bits[res_idx]};
    end
  end

  // One wait state so that read data leaves from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (psel && penable && !pready) begin
        pready  <= 1'b1;
        prdata  <= rdata;
        pslverr <= ~(sel_ctl | sel_cfg | sel_sta | sel_stb | sel_ta | sel_tb | sel_res);
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control and test registers
  // ----------------------------------------------------------------------
  // Soft reset spares power-up enable so the converter stays alive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_channel_control <= `ADSQ_CTL_RESET;
      fast_flag_clear      <= 1'b0;
      power_up_enable      <= 1'b0;
      factory_test_select  <= 4'h0;
      factory_test_output  <= 1'b0;
    end else if (ce) begin
      if (soft_rst) begin
        mode_channel_control <= `ADSQ_CTL_RESET;
        fast_flag_clear      <= 1'b0;
        factory_test_select  <= 4'h0;
        factory_test_output  <= 1'b0;
      end else begin
        if (start) begin
          mode_channel_control <= pwdata[6:0];
        end
        if (wr && sel_cfg && pstrb[0]) begin
          fast_flag_clear <= pwdata[`ADSQ_CFG_FFC];
          power_up_enable <= pwdata[`ADSQ_CFG_PWR];
        end
        if (wr && sel_tb && pstrb[0] && special_mode) begin
          factory_test_select <= pwdata[3:0];
          factory_test_output <= pwdata[`ADSQ_TSTB_TOUT];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Channel decode
  // ----------------------------------------------------------------------
  // Multichannel modes replace the starred select bits by the pointer
  always_comb begin
    if (!multichannel_select) begin
      next_sel = mode_channel_control[3:0];
    end else if (eight_conversion_mode) begin
      next_sel = {mode_channel_control[3], conversion_pointer};
    end else begin
      next_sel = {mode_channel_control[3:2], conversion_pointer[1:0]};
    end
  end

  // Last slot: 8 or 4 conversions per sequence
  assign last = eight_conversion_mode ? (conversion_pointer == 3'd7)
                                      : (conversion_pointer == 3'd3);

  // Mux select registered; code 10xx is reserved and disconnects the mux
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_sel       <= 4'h0;
      analog_sel_valid <= 1'b0;
    end else if (ce) begin
      analog_sel       <= next_sel;
      analog_sel_valid <= ~(next_sel[3] & ~next_sel[2]);
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer and successive approximation
  // ----------------------------------------------------------------------
  // A store that coincides with an abort is dropped: the abort wins
  assign store_evt = (state == st_store) & power_up_enable & ~start & ~soft_rst;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                       <= st_idle;
      conversion_pointer          <= 3'd0;
      sample_cnt                  <= 4'h0;
      bit_idx                     <= 4'h9;
      approximation_register_bits <= 10'h000;
      for (int i = 0; i < 8; i++) begin
        result_bits[i] <= 8'h00;
      end
    end else if (ce) begin
      if (soft_rst) begin
        state                       <= st_idle;
        conversion_pointer          <= 3'd0;
        sample_cnt                  <= 4'h0;
        bit_idx                     <= 4'h9;
        approximation_register_bits <= 10'h000;
        for (int i = 0; i < 8; i++) begin
          result_bits[i] <= 8'h00;
        end
      end else if (start) begin
        // Restart from slot 0, aborting any running sequence
        state              <= power_up_enable ? st_sample : st_idle;
        conversion_pointer <= 3'd0;
        sample_cnt         <= 4'h0;
      end else if (!power_up_enable) begin
        state <= st_idle;
      end else begin
        case (state)
          st_idle: begin
            state <= st_idle;
          end
          st_sample: begin
            if (sample_cnt == 4'(SAMPLE_CYC - 1)) begin
              state                       <= st_resolve;
              approximation_register_bits <= `ADSQ_SAR_INIT;
              bit_idx                     <= 4'h9;
            end else begin
              sample_cnt <= sample_cnt + 4'h1;
            end
          end
          st_resolve: begin
            // Only SAR bits 9..2 are resolved for 8-bit results
            if (!cmp_high) begin
              approximation_register_bits[bit_idx] <= 1'b0;
            end
            if (bit_idx == 4'h2) begin
              state <= st_store;
            end else begin
              approximation_register_bits[bit_idx - 4'h1] <= 1'b1;
              bit_idx                                    <= bit_idx - 4'h1;
            end
          end
          st_store: begin
            result_bits[conversion_pointer] <= approximation_register_bits[9:2];
            sample_cnt                      <= 4'h0;
            if (last) begin
              conversion_pointer <= 3'd0;
              state              <= scan ? st_sample : st_idle;
            end else begin
              conversion_pointer <= conversion_pointer + 3'd1;
              state              <= st_sample;
            end
          end
          default: begin
            state <= st_idle;
          end
        endcase
      end
      // Special-mode writes to the pointer, the SAR and the results
      if (!soft_rst && !start && special_mode && wr && pstrb[0]) begin
        if (sel_stb) begin
          conversion_pointer <= pwdata[2:0];
        end
        if (sel_res) begin
          result_bits[res_idx] <= pwdata[7:0];
        end
      end
      if (!soft_rst && special_mode && wr && sel_ta) begin
        if (pstrb[0]) begin
          approximation_register_bits[7:0] <= pwdata[7:0];
        end
        if (pstrb[1]) begin
          approximation_register_bits[9:8] <= pwdata[9:8];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sequence done flag
  // ----------------------------------------------------------------------
  // Only the first sequence end after a start sets the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sequence_done_flag <= 1'b0;
      seq_ended          <= 1'b0;
    end else if (ce) begin
      if (soft_rst || start) begin
        sequence_done_flag <= 1'b0;
        seq_ended          <= 1'b0;
      end else if (store_evt && last && !seq_ended) begin
        sequence_done_flag <= 1'b1;
        seq_ended          <= 1'b1;
      end else if (special_mode && wr && sel_stb && pstrb[0]) begin
        sequence_done_flag <= pwdata[`ADSQ_STB_SCF];
      end else if (fast_flag_clear && rd && sel_res) begin
        sequence_done_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Channel done flags, one per result slot
  // ----------------------------------------------------------------------
  for (genvar k = 0; k < 8; k++) begin : g_ccf
    logic hit_res;
    assign hit_res = rd & sel_res & (res_idx == 3'(k));

    // Set beats any clear arriving in the same cycle except start or soft reset
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        channel_done_flags[k] <= 1'b0;
        status_armed[k]       <= 1'b0;
      end else if (ce) begin
        if (soft_rst || start) begin
          channel_done_flags[k] <= 1'b0;
          status_armed[k]       <= 1'b0;
        end else if (store_evt && conversion_pointer == 3'(k)) begin
          channel_done_flags[k] <= 1'b1;
        end else if (special_mode && wr && sel_sta && pstrb[0]) begin
          channel_done_flags[k] <= pwdata[k];
          status_armed[k]       <= 1'b0;
        end else if (hit_res && (fast_flag_clear || status_armed[k])) begin
          channel_done_flags[k] <= 1'b0;
          status_armed[k]       <= 1'b0;
        end else if (rd && sel_sta && channel_done_flags[k]) begin
          status_armed[k] <= 1'b1;
        end
      end
    end
  end

endmodule

// ==== tb/adsq_monitor.sv ====
/*
  Port checker of the ADC conversion sequencer: APB timing, refusals,
  mux decode, test outputs. Assumes it is bound into adsq_top, ce high.
*/
`timescale 1ns/1ps
`include "adsq_regs.svh"

module adsq_monitor #(
  parameter int ADDR_W = 12
) (
  // Clock, reset, enable
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                ce,
  // APB slave
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [ADDR_W-1:0]   paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [3:0]          pstrb,
  input wire logic                pready,
  input wire logic [31:0]         prdata,
  input wire logic                pslverr,
  // Chip mode and analog side
  input wire logic                special_mode,
  input wire logic                cmp_high,
  input wire adsq_pkg::adsq_sel_t analog_sel,
  input wire logic                analog_sel_valid,
  input wire logic [7:0]          dac_code,
  // Factory test
  input wire logic [3:0]          factory_test_select,
  input wire logic                factory_test_output
);
  import adsq_pkg::*;

  // ------------------------------
  // Bus decode
  // ------------------------------
  logic acc_first;
  logic wr_done;
  logic ctrl_wr;
  logic wr_test_b;
  logic hit_test;
  logic hit_none;
  // Writes commit at the edge that ends the pready cycle
  assign acc_first = psel && penable && !pready;
  assign wr_done   = pready && pwrite && !pslverr && pstrb[0];
  assign ctrl_wr   = wr_done && paddr == `ADSQ_OFF_CTRL;
  assign wr_test_b = wr_done && special_mode && paddr == `ADSQ_OFF_TEST_B;
  assign hit_test  = paddr == `ADSQ_OFF_TEST_A || paddr == `ADSQ_OFF_TEST_B;
  assign hit_none  = paddr == 12'h018 || paddr == 12'h01C || paddr >= 12'h040;

  default clocking mon_cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);

  sequence s_setup_access;
    psel && !penable ##1 psel && penable;
  endsequence

  // ------------------------------
  // Properties
  // ------------------------------
  chk_one_wait: assert property (s_setup_access |=> pready)
    else $error("pready missing in second access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  chk_unmapped_error: assert property (acc_first && hit_none |=> pready && pslverr)
    else $error("unmapped access not refused");
  chk_test_hidden: assert property (
    acc_first && hit_test && !pwrite && !special_mode |=> prdata == 32'h0)
    else $error("test register visible in normal mode");
  chk_byte_regs: assert property (
    pready && !pwrite && paddr != `ADSQ_OFF_TEST_A |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_single_sel: assert property (
    ctrl_wr && !pwdata[`ADSQ_CTL_MULTICHANNEL_SELECT] |-> ##2 analog_sel == $past(pwdata[3:0], 2))
    else $error("single channel select not applied");
  chk_multichannel_select_first: assert property (
    ctrl_wr && pwdata[`ADSQ_CTL_MULTICHANNEL_SELECT] |-> ##2 analog_sel == ($past(pwdata[6], 2) ?
      {$past(pwdata[3], 2), 3'h0} : {$past(pwdata[3:2], 2), 2'h0}))
    else $error("multichannel run not starting at its first input");
  chk_mux_valid: assert property (
    $past(presetn) |-> analog_sel_valid == (analog_sel[3:2] != 2'h2))
    else $error("mux valid disagrees with select code");
  chk_test_outputs: assert property (
    $changed({factory_test_select, factory_test_output}) |-> $past(wr_test_b)
      || $past(wr_test_b, 2))
    else $error("test outputs moved without a special write");
  chk_sar_load: assert property (
    wr_done && special_mode && paddr == `ADSQ_OFF_TEST_A && pstrb[1]
      |=> dac_code == $past(pwdata[9:2]))
    else $error("approximation write not loaded");
endmodule

bind adsq_top adsq_monitor #(.ADDR_W(ADDR_W)) mon_u (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .special_mode(special_mode), .cmp_high(cmp_high),
  .analog_sel(analog_sel), .analog_sel_valid(analog_sel_valid), .dac_code(dac_code),
  .factory_test_select(factory_test_select), .factory_test_output(factory_test_output));

// ==== tb/adsq_analog_model.sv ====
/*
  Analog mux and comparator seen by the sequencer.
  Assumes the design samples cmp_high against dac_code each resolve cycle.
*/
`timescale 1ns/1ps

module adsq_analog_model (
  // Clock
  input  wire logic                pclk,
  // Mux select and DAC from the sequencer
  input  wire adsq_pkg::adsq_sel_t analog_sel,
  input  wire logic                analog_sel_valid,
  input  wire logic [7:0]          dac_code,
  // Comparator answer
  output logic                     cmp_high
);
  import adsq_pkg::*;

  // ------------------------------
  // Comparator
  // ------------------------------
  logic junk = 1'h0;
  // A disabled mux has no level, so the answer toggles rather than settle
  always_ff @(posedge pclk) begin
    junk <= ~junk;
  end
  // Each input sits at its select code followed by that code inverted, so a full SAR lands on it
  assign cmp_high = analog_sel_valid ? ({analog_sel, ~analog_sel} >= dac_code) : junk;
endmodule

// ==== tb/adsq_top_test.sv ====
/*
  Self-checking bench of the ADC conversion sequencer, driven over APB.
  Assumes the analog model answers the comparator and the checker is bound.
*/
`timescale 1ns/1ps
`include "adsq_regs.svh"

// Counts a comparison and reports a mismatch at once
`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end

module adsq_top_test;
  import adsq_pkg::*;

  // ------------------------------
  // Signals
  // ------------------------------
  logic        pclk = 1'h0, presetn = 1'h0, ce = 1'h1, psel = 1'h0, penable = 1'h0;
  logic        pwrite = 1'h0, special_mode = 1'h0, cmp_high;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hF, factory_test_select;
  logic [7:0]  dac_code;
  adsq_sel_t   analog_sel;
  logic        pready, pslverr, analog_sel_valid, factory_test_output;
  int          bad_count = 0, checks_done = 0;

  // 100 MHz clock
  always #5 pclk = ~pclk;

  adsq_top dut_u (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .special_mode(special_mode), .cmp_high(cmp_high),
    .analog_sel(analog_sel), .analog_sel_valid(analog_sel_valid), .dac_code(dac_code),
    .factory_test_select(factory_test_select), .factory_test_output(factory_test_output));

  adsq_analog_model ana_u (.pclk(pclk), .analog_sel(analog_sel),
    .analog_sel_valid(analog_sel_valid), .dac_code(dac_code), .cmp_high(cmp_high));

  // ------------------------------
  // Helpers
  // ------------------------------
  // Level code of each mux input, as the analog model presents it
  function automatic logic [7:0] lvl(input logic [3:0] k);
    return {k, ~k};
  endfunction

  function automatic logic [11:0] res(input int k);
    return `ADSQ_OFF_RES0 + 12'(4 * k);
  endfunction

  task automatic results();
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic hang();
    bad_count++;
    $display("mismatch at %0t: wait ran out", $time);
    results();
  endtask

  // One transfer; an idle cycle after it keeps drivers from double assignment
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) hang();
    rd      = prdata;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    `CHK(rd, e)
  endtask

  task automatic poll(input logic [11:0] a, input logic [31:0] m);
    int n;
    n = 0;
    do begin
      apb(1'h0, a, 32'h0);
      n++;
    end while ((rd & m) !== m && n < 200);
    if ((rd & m) !== m) hang();
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_reset();
    rdchk(`ADSQ_OFF_STAT_A, 32'h0);
    rdchk(`ADSQ_OFF_STAT_B, 32'h0);
    rdchk(`ADSQ_OFF_TEST_A, 32'h0);
    apb(1'h0, 12'h018, 32'h0);
    apb(1'h1, `ADSQ_OFF_TEST_B, 32'h4B);
    rdchk(`ADSQ_OFF_CFG, 32'h0);
    `CHK(factory_test_select, 4'h0)
  endtask

  task automatic t_single();
    apb(1'h1, `ADSQ_OFF_CFG, 32'h2);
    apb(1'h1, `ADSQ_OFF_CTRL, 32'h6);
    poll(`ADSQ_OFF_STAT_B, 32'h80);
    for (int k = 0; k < 4; k++) rdchk(res(k), lvl(4'h6));
    rdchk(res(4), 32'h0);
    rdchk(`ADSQ_OFF_STAT_A, 32'h0F);
    rdchk(res(2), lvl(4'h6));
    rdchk(`ADSQ_OFF_STAT_A, 32'h0B);
    apb(1'h0, `ADSQ_OFF_STAT_B, 32'h0);
    `CHK(rd[7], 1'h1)
    apb(1'h1, res(0), 32'h55);
    rdchk(res(0), lvl(4'h6));
  endtask

  // Don't-care select bits carry junk on purpose
  task automatic t_multichannel_select();
    apb(1'h1, `ADSQ_OFF_CTRL, 32'h53);
    apb(1'h0, `ADSQ_OFF_STAT_B, 32'h0);
    `CHK(rd[2:0], 3'h0)
    poll(`ADSQ_OFF_STAT_B, 32'h80);
    for (int k = 0; k < 8; k++) rdchk(res(k), lvl(4'(k)));
    apb(1'h1, `ADSQ_OFF_CTRL, 32'h1E);
    poll(`ADSQ_OFF_STAT_B, 32'h80);
    for (int k = 0; k < 4; k++) rdchk(res(k), lvl(4'(12 + k)));
    rdchk(res(7), lvl(4'h7));
    apb(1'h1, `ADSQ_OFF_CTRL, 32'h15);
    poll(`ADSQ_OFF_STAT_B, 32'h80);
    for (int k = 0; k < 4; k++) rdchk(res(k), lvl(4'(4 + k)));
  endtask

  // Fast clearing on a four-conversion run, then an eight-conversion scan on one input, then an abort
  task automatic t_fast_scan();
    apb(1'h1, `ADSQ_OFF_CFG, 32'h3);
    apb(1'h1, `ADSQ_OFF_CTRL, 32'h0);
    poll(`ADSQ_OFF_STAT_B, 32'h80);
    rdchk(res(1), lvl(4'h0));
    rdchk(`ADSQ_OFF_STAT_A, 32'h0D);
    apb(1'h0, `ADSQ_OFF_STAT_B, 32'h0);
    `CHK(rd[7], 1'h0)
    apb(1'h1, `ADSQ_OFF_CTRL, 32'h65);
    poll(`ADSQ_OFF_STAT_B, 32'h80);
    rdchk(res(1), lvl(4'h5));
    rdchk(res(7), lvl(4'h5));
    poll(`ADSQ_OFF_STAT_A, 32'h02);
    apb(1'h0, `ADSQ_OFF_STAT_B, 32'h0);
    `CHK(rd[7], 1'h0)
    apb(1'h1, `ADSQ_OFF_CTRL, 32'h5);
    rdchk(`ADSQ_OFF_STAT_A, 32'h0);
    apb(1'h0, `ADSQ_OFF_STAT_B, 32'h0);
    `CHK(rd[7], 1'h0)
    poll(`ADSQ_OFF_STAT_B, 32'h80);
  endtask

  task automatic t_special();
    special_mode <= 1'h1;
    apb(1'h1, `ADSQ_OFF_TEST_A, 32'h2A8);
    rdchk(`ADSQ_OFF_TEST_A, 32'h2A8);
    `CHK(dac_code, 8'hAA)
    apb(1'h1, `ADSQ_OFF_TEST_B, 32'h4B);
    rdchk(`ADSQ_OFF_TEST_B, 32'h4B);
    `CHK({factory_test_output, factory_test_select}, 5'h1B)
    special_mode <= 1'h0;
    rdchk(`ADSQ_OFF_TEST_B, 32'h0);
    special_mode <= 1'h1;
    apb(1'h1, `ADSQ_OFF_STAT_A, 32'h0);
    rdchk(`ADSQ_OFF_STAT_A, 32'h0);
    apb(1'h1, `ADSQ_OFF_TEST_B, 32'h80);
    rdchk(`ADSQ_OFF_CFG, 32'h2);
    rdchk(res(0), 32'h0);
    `CHK(factory_test_select, 4'h0)
    special_mode <= 1'h0;
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset();
    t_single();
    t_multichannel_select();
    t_fast_scan();
    t_special();
    results();
  end
endmodule
